// >>> src/snv_defs.vh
/*
 * Constants for the serial nonvolatile memory slave: op-codes, status bit
 * positions, reset values, protected range starts and wake-up timing.
 * Assumes it is included by bare name from files under src/.
 */
`ifndef SNV_DEFS_VH
`define SNV_DEFS_VH

// op-codes, all eight bits, sent msb first
`define SNV_OP_SET_WRITE_LATCH 8'h06
`define SNV_OP_CLEAR_WRITE_LATCH 8'h04
`define SNV_OP_STATUS_READ 8'h05
`define SNV_OP_STATUS_WRITE 8'h01
`define SNV_OP_ARRAY_READ 8'h03
`define SNV_OP_ARRAY_WRITE 8'h02
`define SNV_OP_FAST_ARRAY_READ 8'h0b
`define SNV_OP_DEEP_SLEEP 8'hba
`define SNV_OP_DEVICE_IDENT_READ 8'h9f
`define SNV_OP_UNIQUE_IDENT_READ 8'h4c
`define SNV_OP_SERIAL_NUMBER_WRITE 8'hc2
`define SNV_OP_SERIAL_NUMBER_READ 8'hc3
`define SNV_OP_SPECIAL_SECTOR_WRITE 8'h42
`define SNV_OP_SPECIAL_SECTOR_READ 8'h4b
`define SNV_OP_FAST_SPECIAL_SECTOR_READ 8'h49

// status register bit positions
`define SNV_ST_GUARD_EN 7
`define SNV_ST_SPARE_HI 6
`define SNV_ST_SPARE_LO 4
`define SNV_ST_BLOCK_HI 3
`define SNV_ST_BLOCK_LO 2
`define SNV_ST_WEL 1
`define SNV_ST_ZERO 0

// reset values of the stored status bits (7..2) and of the latch
`define SNV_ST_NV_RESET 6'h00
`define SNV_WEL_RESET 1'b0

// array geometry and protected range starts
`define SNV_ADDR_W 18
`define SNV_ARRAY_WORDS 262144
`define SNV_PROT_QUARTER 18'h30000
`define SNV_PROT_HALF 18'h20000

// serial counts
`define SNV_ADDR_BITS 5'd23
`define SNV_BYTE_LAST 5'd7

// deep sleep recovery: time in ns, clock rate in MHz, count rounded down
`define SNV_T_RECDPD_NS 10000
`define SNV_MCLK_MHZ 20
`define SNV_RECDPD_CYC ((`SNV_T_RECDPD_NS * `SNV_MCLK_MHZ) / 1000)

`endif

// >>> src/snv_core.v
/*
 * Serial nonvolatile memory slave: op-code decode, status register with
 * write latch and guard bits, array read and write with wrap-around.
 * Assumes mclk is well above the serial clock rate (at least 8x), and
 * that cs_n, sck, si and write_guard_n are asynchronous pins.
 */
// Notes on behaviour
// - bit 7 guards status writes with pin
// - bits 6..4 stored and read back
// - bits 3..2 choose protected array region
// - bit 1 shows write latch, set/clear only
// - latch clears at reset, clear command, wake
// - latch kept after status/serial/sector writes
// - bit 0 always reads zero
// - short op-code at deselect runs nothing
// - latch set 06h, latch clear 04h
// - status read 05h, write 01h, read 03h
// - array write 02h, fast read 0bh
// - sleep bah, ident 9fh, unique 4ch
// - serial write c2h, read c3h, sector 42h
// - sector read 4bh, fast sector read 49h
// - clear latch blocks all write commands
// - status byte out on falls, repeating
// - status write keeps latch and zero bit
// - array read: 18-bit address, increments, wraps
// - array write: byte per 8 bits, wraps
// - sample on rise, drive on fall
// - deselected: output released, inputs ignored
// - guard bits protect none, quarter, half, all
// - status write blocked by clear latch, or by bit 7 with pin low
`timescale 1ns/1ps
`include "snv_defs.vh"

module snv_core (
    input wire mclk,
    input wire sys_rst,
    input wire cs_n,
    input wire sck,
    input wire si,
    input wire write_guard_n,
    output reg so_out,
    output reg so_oe_n
);

    // one-hot command states
    localparam [8:0] ST_OPCODE = 9'h001;
    localparam [8:0] ST_ADDR = 9'h002;
    localparam [8:0] ST_DUMMY = 9'h004;
    localparam [8:0] ST_ARR_RD = 9'h008;
    localparam [8:0] ST_ARR_WR = 9'h010;
    localparam [8:0] ST_STAT_RD = 9'h020;
    localparam [8:0] ST_STAT_WR = 9'h040;
    localparam [8:0] ST_SLEEP_ARM = 9'h080;
    localparam [8:0] ST_IGNORE = 9'h100;

    // address phase targets
    localparam [1:0] AT_READ = 2'h0;
    localparam [1:0] AT_FAST = 2'h1;
    localparam [1:0] AT_WRITE = 2'h2;

    reg [7:0] mem [0:`SNV_ARRAY_WORDS-1];

    reg cs_s1, cs_s2, cs_d;
    reg sck_s1, sck_s2, sck_d;
    reg si_s1, si_s2;
    reg wg_s1, wg_s2;

    reg [8:0] state;
    reg [1:0] addr_target;
    reg [4:0] cnt;
    reg [7:0] in_sh;
    reg [23:0] addr_sh;
    reg [`SNV_ADDR_W-1:0] addr;
    reg [7:0] out_sh;
    reg [5:0] nv_status;
    reg write_enable_latch;
    reg sleeping;
    reg waking;
    reg [7:0] wake_cnt;

    wire sck_rise;
    wire sck_fall;
    wire cs_fall;
    wire cs_rise;
    wire selected;
    wire active;
    wire [7:0] in_byte;
    wire [7:0] status_byte;
    wire byte_done;
    wire addr_protected;
    wire status_locked;
    wire [23:0] addr_full;
    wire wake_done;

    // two flip-flops on every pin before any logic reads it
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_d <= 1'b1;
            sck_s1 <= 1'b0;
            sck_s2 <= 1'b0;
            sck_d <= 1'b0;
            si_s1 <= 1'b0;
            si_s2 <= 1'b0;
            wg_s1 <= 1'b1;
            wg_s2 <= 1'b1;
        end else begin
            cs_s1 <= cs_n;
            cs_s2 <= cs_s1;
            cs_d <= cs_s2;
            sck_s1 <= sck;
            sck_s2 <= sck_s1;
            sck_d <= sck_s2;
            si_s1 <= si;
            si_s2 <= si_s1;
            wg_s1 <= write_guard_n;
            wg_s2 <= wg_s1;
        end
    end

    // edges seen from the synchronised copies only
    assign cs_fall = cs_d & ~cs_s2;
    assign cs_rise = ~cs_d & cs_s2;
    assign sck_rise = ~sck_d & sck_s2;
    assign sck_fall = sck_d & ~sck_s2;
    assign selected = ~cs_s2;
    // while asleep or waking, clock and data edges are dropped
    assign active = selected & ~sleeping & ~waking & ~cs_rise;

    assign in_byte = {in_sh[6:0], si_s2};
    assign byte_done = (cnt == `SNV_BYTE_LAST);
    assign addr_full = {addr_sh[22:0], si_s2};

    // one-cycle mark at the end of the recovery time after a wake;
    // the latch is cleared on this mark, not at the select edge
    assign wake_done = waking && (wake_cnt == (`SNV_RECDPD_CYC - 1));

    // bit 0 fixed low, bit 1 mirrors the latch
    assign status_byte = {nv_status, write_enable_latch, 1'b0};

    // a set guard enable with the guard pin low freezes the status bits
    assign status_locked = nv_status[`SNV_ST_GUARD_EN-2] & ~wg_s2;

    // protected range chosen by the two block guard bits
    function prot_hit;
        input [1:0] guard;
        input [`SNV_ADDR_W-1:0] a;
        begin
            case (guard)
                2'b00: prot_hit = 1'b0;
                2'b01: prot_hit = (a >= `SNV_PROT_QUARTER);
                2'b10: prot_hit = (a >= `SNV_PROT_HALF);
                default: prot_hit = 1'b1;
            endcase
        end
    endfunction

    assign addr_protected = prot_hit(nv_status[`SNV_ST_BLOCK_HI-2:`SNV_ST_BLOCK_LO-2], addr);

    // array write port; the latch and the guard range both gate it
    always @(posedge mclk) begin
        if (active && sck_rise && state == ST_ARR_WR && byte_done && write_enable_latch && !addr_protected) begin
            mem[addr] <= in_byte;
        end
    end

    // command sequencer: bits in on rising sck, bytes out on falling sck
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= ST_OPCODE;
            addr_target <= AT_READ;
            cnt <= 5'd0;
            in_sh <= 8'h00;
            addr_sh <= 24'h000000;
            addr <= {`SNV_ADDR_W{1'b0}};
            out_sh <= 8'h00;
            nv_status <= `SNV_ST_NV_RESET;
            write_enable_latch <= `SNV_WEL_RESET;
        end else if (cs_rise || !selected) begin
            // end of frame: a partial op-code simply never decodes
            state <= ST_OPCODE;
            cnt <= 5'd0;
            // the wake timer may finish while the host is deselected
            if (wake_done) begin
                write_enable_latch <= 1'b0;
            end
        end else if (sleeping || waking) begin
            // clock and data are dropped until the recovery time is over;
            // the host must not start a command before then
            if (wake_done) begin
                write_enable_latch <= 1'b0;
            end
        end else if (sck_rise) begin
            in_sh <= in_byte;
            cnt <= byte_done ? 5'd0 : cnt + 5'd1;
            case (state)
                ST_OPCODE: begin
                    if (byte_done) begin
                        // unlisted codes fall to ignore; the host sends none
                        case (in_byte)
                            `SNV_OP_SET_WRITE_LATCH: begin
                                write_enable_latch <= 1'b1;
                                state <= ST_IGNORE;
                            end
                            `SNV_OP_CLEAR_WRITE_LATCH: begin
                                write_enable_latch <= 1'b0;
                                state <= ST_IGNORE;
                            end
                            `SNV_OP_STATUS_READ: state <= ST_STAT_RD;
                            `SNV_OP_STATUS_WRITE: state <= ST_STAT_WR;
                            `SNV_OP_ARRAY_READ: begin
                                addr_target <= AT_READ;
                                state <= ST_ADDR;
                            end
                            `SNV_OP_ARRAY_WRITE: begin
                                addr_target <= AT_WRITE;
                                state <= ST_ADDR;
                            end
                            `SNV_OP_FAST_ARRAY_READ: begin
                                addr_target <= AT_FAST;
                                state <= ST_ADDR;
                            end
                            `SNV_OP_DEEP_SLEEP: state <= ST_SLEEP_ARM;
                            // these leave the latch as it stands, no storage here
                            `SNV_OP_SERIAL_NUMBER_WRITE,
                            `SNV_OP_SPECIAL_SECTOR_WRITE: state <= ST_IGNORE;
                            default: state <= ST_IGNORE;
                        endcase
                    end
                end
                ST_ADDR: begin
                    addr_sh <= addr_full;
                    // the address runs 24 bits, past the byte counter wrap
                    cnt <= (cnt == `SNV_ADDR_BITS) ? 5'd0 : cnt + 5'd1;
                    if (cnt == `SNV_ADDR_BITS) begin
                        // upper six address bits dropped
                        addr <= addr_full[`SNV_ADDR_W-1:0];
                        case (addr_target)
                            AT_WRITE: state <= ST_ARR_WR;
                            AT_FAST: state <= ST_DUMMY;
                            default: state <= ST_ARR_RD;
                        endcase
                    end
                end
                ST_DUMMY: begin
                    if (byte_done) begin
                        state <= ST_ARR_RD;
                    end
                end
                ST_ARR_WR: begin
                    if (byte_done) begin
                        // natural overflow of the address gives the wrap
                        addr <= addr + {{(`SNV_ADDR_W-1){1'b0}}, 1'b1};
                    end
                end
                ST_STAT_WR: begin
                    if (byte_done) begin
                        // latch and zero bit positions of the input dropped
                        if (write_enable_latch && !status_locked) begin
                            nv_status <= in_byte[7:2];
                        end
                        state <= ST_IGNORE;
                    end
                end
                ST_SLEEP_ARM: begin
                    // any rising sck after the op-code cancels the sleep
                    state <= ST_IGNORE;
                end
                default: begin
                    // read states and ignore just count bits; si unused
                end
            endcase
        end else if (sck_fall) begin
            // the fall that ends the last op-code bit must not cancel a
            // pending sleep in mode 0, so only a later rise cancels it
            if (state == ST_STAT_RD) begin
                // byte boundary reloads, so the status byte repeats
                out_sh <= (cnt == 5'd0) ? status_byte : {out_sh[6:0], 1'b0};
            end else if (state == ST_ARR_RD) begin
                if (cnt == 5'd0) begin
                    out_sh <= mem[addr];
                    addr <= addr + {{(`SNV_ADDR_W-1){1'b0}}, 1'b1};
                end else begin
                    out_sh <= {out_sh[6:0], 1'b0};
                end
            end
        end
    end

    // output pin: data from the shifter, enable low only during read bytes
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            so_out <= 1'b0;
            so_oe_n <= 1'b1;
        end else begin
            so_out <= out_sh[7];
            so_oe_n <= ~(active && (state == ST_STAT_RD || state == ST_ARR_RD));
        end
    end

    // deep sleep entry and wake timer; kept apart from the sequencer so
    // the timer keeps running when the host raises select again before
    // the recovery time is over, which the host is allowed to do
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sleeping <= 1'b0;
            waking <= 1'b0;
            wake_cnt <= 8'h00;
        end else if (sleeping) begin
            // a falling select is the only way out of sleep
            if (cs_fall) begin
                sleeping <= 1'b0;
                waking <= 1'b1;
                wake_cnt <= 8'h00;
            end
        end else if (waking) begin
            if (wake_done) begin
                waking <= 1'b0;
            end else begin
                wake_cnt <= wake_cnt + 8'h01;
            end
        end else if (cs_rise && state == ST_SLEEP_ARM) begin
            // entry only at the select rise right after the op-code
            sleeping <= 1'b1;
        end
    end

endmodule

// >>> bench/snv_core_asserts.sv
/* checker: timing relations at the pins of the serial memory slave.
   assumes an sck half period of 4 mclk and the 2-ff pin synchronisers. */
`timescale 1ns/1ps
module snv_core_asserts (
    input wire mclk,
    input wire sys_rst,
    input wire cs_n,
    input wire sck,
    input wire si,
    input wire write_guard_n,
    input wire so_out,
    input wire so_oe_n
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    // so released once a deselect has passed the synchroniser
    a_deselect_released: assert property (cs_n [*6] |-> so_oe_n)
        else $error("so driven while deselected");
    a_drive_needs_select: assert property (!so_oe_n |-> !$past(cs_n, 6))
        else $error("so driven without select");
    a_drive_stands: assert property ((!so_oe_n && !cs_n) ##1 !cs_n [*4] |-> !so_oe_n)
        else $error("so released inside a read frame");
    a_release_cause: assert property ($rose(so_oe_n) |-> $past(cs_n, 3))
        else $error("so released without deselect");
    a_drive_start: assert property ($fell(so_oe_n) |-> !cs_n && !$past(cs_n, 3))
        else $error("so driven at select edge");
    // a new bit may only follow a falling sck, never a rising one
    a_out_on_fall: assert property (!so_oe_n && $changed(so_out) |-> !$past(sck, 2))
        else $error("so changed after a rising sck");
    // inputs are ignored while deselected, so nothing moves on so
    a_quiet_deselect: assert property (cs_n [*8] |-> $stable(so_out))
        else $error("so toggled while deselected");
    a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=> so_oe_n)
        else $error("so driven during reset");
endmodule

bind snv_core snv_core_asserts snv_core_asserts_inst (
    .mclk(mclk), .sys_rst(sys_rst), .cs_n(cs_n), .sck(sck), .si(si),
    .write_guard_n(write_guard_n), .so_out(so_out), .so_oe_n(so_oe_n)
);

// >>> bench/snv_host_model.sv
/* partner: spi host in mode 0 that frames commands and reads so.
   assumes it is called from the bench just after a rising mclk edge. */
`timescale 1ns/1ps
`include "snv_defs.vh"
module snv_host_model (
    input wire mclk,
    input wire so_out,
    input wire so_oe_n,
    output reg cs_n,
    output reg sck,
    output reg si
);
    // a released so shows the inverse, so a stale bit cannot pass
    wire so_seen = so_oe_n ? ~so_out : so_out;
    reg [7:0] junk;
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    task tick(input integer n);
        integer k;
        begin
            for (k = 0; k < n; k = k + 1) @(posedge mclk);
        end
    endtask
    // sck stands still between frames; cs low settles before the first rise
    task open_frame;
        begin
            cs_n <= 1'b0;
            tick(4);
        end
    endtask
    task close_frame;
        begin
            tick(4);
            cs_n <= 1'b1;
            tick(8);
        end
    endtask
    // si moves with sck low, so is read late in the high phase
    task xfer(input [7:0] tx, input integer nbits, output [7:0] rx);
        integer i;
        begin
            rx = 8'h00;
            for (i = 7; i > 7 - nbits; i = i - 1) begin
                si <= tx[i];
                tick(4);
                sck <= 1'b1;
                tick(3);
                rx[i] = so_seen;
                tick(1);
                sck <= 1'b0;
            end
        end
    endtask
    task put(input [7:0] tx);
        xfer(tx, 8, junk);
    endtask
    // only listed op-codes are ever sent
    task op_frame(input [7:0] op);
        begin
            open_frame;
            put(op);
            close_frame;
        end
    endtask
    task status_rd(output [7:0] s0, output [7:0] s1);
        begin
            open_frame;
            put(`SNV_OP_STATUS_READ);
            xfer(8'h00, 8, s0);
            xfer(8'h00, 8, s1);
            close_frame;
        end
    endtask
    task status_wr(input [7:0] v);
        begin
            open_frame;
            put(`SNV_OP_STATUS_WRITE);
            put(v);
            close_frame;
        end
    endtask
    task mem_rd(input [7:0] op, input [23:0] a, output [7:0] d0, output [7:0] d1);
        begin
            open_frame;
            put(op);
            put(a[23:16]);
            put(a[15:8]);
            put(a[7:0]);
            if (op == `SNV_OP_FAST_ARRAY_READ) put(8'h00);
            xfer(8'h00, 8, d0);
            xfer(8'h00, 8, d1);
            close_frame;
        end
    endtask
    task mem_wr(input [23:0] a, input [7:0] d0, input [7:0] d1);
        begin
            open_frame;
            put(`SNV_OP_ARRAY_WRITE);
            put(a[23:16]);
            put(a[15:8]);
            put(a[7:0]);
            put(d0);
            put(d1);
            close_frame;
        end
    endtask
endmodule

// >>> bench/spi_nvram_status_and_array_access_test.sv
/* bench: status, guard pin, array wrap, block guard and short op-code.
   assumes snv_core and the host model; the host makes the 400 ns link. */
`timescale 1ns/1ps
`include "snv_defs.vh"
module spi_nvram_status_and_array_access_test;
    reg mclk = 1'b0;
    reg sys_rst = 1'b1;
    reg write_guard_n = 1'b1;
    wire cs_n;
    wire sck;
    wire si;
    wire so_out;
    wire so_oe_n;
    integer n_mismatch = 0;
    integer cmp_count = 0;
    integer cycles = 0;
    reg [7:0] b0;
    reg [7:0] b1;
    always #25 mclk = ~mclk;
    snv_core snv_core_inst (.mclk(mclk), .sys_rst(sys_rst), .cs_n(cs_n), .sck(sck),
        .si(si), .write_guard_n(write_guard_n), .so_out(so_out), .so_oe_n(so_oe_n));
    snv_host_model snv_host_model_inst (.mclk(mclk), .so_out(so_out),
        .so_oe_n(so_oe_n), .cs_n(cs_n), .sck(sck), .si(si));
    task check(input [63:0] what, input [7:0] exp, input [7:0] got);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("mismatch %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task wrap_up;
        begin
            $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
            if (n_mismatch == 0 && cmp_count > 0) $display("SIMULATION PASSED");
            else $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    // latch, fixed bits and repeated status byte
    task t_status;
        begin
            snv_host_model_inst.status_rd(b0, b1);
            check("st_reset", 8'h00, b0);
            snv_host_model_inst.status_wr(8'hff);
            snv_host_model_inst.status_rd(b0, b1);
            check("st_nolat", 8'h00, b0);
            snv_host_model_inst.op_frame(`SNV_OP_SET_WRITE_LATCH);
            snv_host_model_inst.status_rd(b0, b1);
            check("st_latch", 8'h02, b0);
            snv_host_model_inst.status_wr(8'hff);
            snv_host_model_inst.status_rd(b0, b1);
            check("st_full", 8'hfe, b0);
            check("st_again", 8'hfe, b1);
            snv_host_model_inst.op_frame(`SNV_OP_CLEAR_WRITE_LATCH);
            snv_host_model_inst.status_rd(b0, b1);
            check("st_clear", 8'hfc, b0);
        end
    endtask
    // guard bit plus low pin locks status; high pin frees it
    task t_guard;
        begin
            snv_host_model_inst.op_frame(`SNV_OP_SET_WRITE_LATCH);
            write_guard_n <= 1'b0;
            snv_host_model_inst.status_wr(8'h00);
            snv_host_model_inst.status_rd(b0, b1);
            check("gd_lock", 8'hfe, b0);
            write_guard_n <= 1'b1;
            snv_host_model_inst.status_wr(8'h00);
            snv_host_model_inst.status_rd(b0, b1);
            check("gd_free", 8'h02, b0);
        end
    endtask
    // top address wraps to zero; upper address bits are dropped
    task t_array;
        begin
            snv_host_model_inst.mem_wr(24'hffffff, 8'ha5, 8'h5a);
            snv_host_model_inst.mem_rd(`SNV_OP_ARRAY_READ, 24'h03ffff, b0, b1);
            check("rd_top", 8'ha5, b0);
            check("rd_wrap", 8'h5a, b1);
            snv_host_model_inst.mem_rd(`SNV_OP_FAST_ARRAY_READ, 24'hfffffe, b0, b1);
            check("fast_top", 8'ha5, b1);
        end
    endtask
    // quarter guard blocks 30000h and up, not 2ffffh; a clear latch blocks all
    task t_block;
        begin
            snv_host_model_inst.op_frame(`SNV_OP_SET_WRITE_LATCH);
            snv_host_model_inst.mem_wr(24'h02ffff, 8'h11, 8'h22);
            snv_host_model_inst.op_frame(`SNV_OP_SET_WRITE_LATCH);
            snv_host_model_inst.status_wr(8'h04);
            snv_host_model_inst.mem_wr(24'h02ffff, 8'h33, 8'h44);
            snv_host_model_inst.mem_rd(`SNV_OP_ARRAY_READ, 24'h02ffff, b0, b1);
            check("bg_open", 8'h33, b0);
            check("bg_guard", 8'h22, b1);
            snv_host_model_inst.op_frame(`SNV_OP_CLEAR_WRITE_LATCH);
            snv_host_model_inst.mem_wr(24'h02ffff, 8'h55, 8'h66);
            snv_host_model_inst.mem_rd(`SNV_OP_ARRAY_READ, 24'h02ffff, b0, b1);
            check("wr_nolat", 8'h33, b0);
        end
    endtask
    // seven bits of the latch op-code then deselect: nothing runs
    task t_short;
        begin
            snv_host_model_inst.open_frame;
            snv_host_model_inst.xfer(`SNV_OP_SET_WRITE_LATCH, 7, b0);
            snv_host_model_inst.close_frame;
            snv_host_model_inst.status_rd(b0, b1);
            check("short_op", 8'h04, b0);
        end
    endtask
    // sleep with the latch set; the wake must clear the latch
    task t_sleep;
        begin
            snv_host_model_inst.op_frame(`SNV_OP_SET_WRITE_LATCH);
            snv_host_model_inst.op_frame(`SNV_OP_DEEP_SLEEP);
            snv_host_model_inst.open_frame;
            snv_host_model_inst.tick(220);
            snv_host_model_inst.close_frame;
            snv_host_model_inst.status_rd(b0, b1);
            check("sl_wake", 8'h04, b0);
        end
    endtask
    // bounded run: a hang counts as a mismatch
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_mismatch = n_mismatch + 1;
            wrap_up;
        end
    end
    initial begin
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (6) @(posedge mclk);
        t_status;
        t_guard;
        t_array;
        t_block;
        t_short;
        t_sleep;
        wrap_up;
    end
endmodule
